// *** sccr_crc_byte.v ***
// group check register fed one byte at a time, first received bit first
`timescale 1ns/1ns
`include "sccr_regs.vh"
module sccr_crc_byte (
	input wire clock,
	input wire reset_n,
	input wire clear,
	input wire byteValid,
	input wire [7:0] byteIn,
	output wire allZero
);
	reg [15:0] crc_r;
	reg [15:0] crc_nxt;
	integer i;

	// eight serial shift steps unrolled by a loop
	always @* begin
		crc_nxt = crc_r;
		for (i = 0; i < `SCCR_BYTE_BITS; i = i + 1) begin
			if (crc_nxt[15] ^ byteIn[i]) begin
				crc_nxt = {crc_nxt[14:0], 1'b0} ^ `SCCR_CRC_POLY;
			end else begin
				crc_nxt = {crc_nxt[14:0], 1'b0};
			end
		end
	end

	// clear holds the register at its start value while set
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			crc_r <= `SCCR_CRC_INIT;
		end else if (clear) begin
			crc_r <= `SCCR_CRC_INIT;
		end else if (byteValid) begin
			crc_r <= crc_nxt;
		end
	end

	assign allZero = (crc_r == 16'h0000);
endmodule

// *** sccr_host_model.sv ***
// host model acting as master of the serial control port
`timescale 1ns/1ns
module sccr_host_model (
	output logic chipEnable,
	output logic serial_clock_in,
	output logic serial_data_in,
	input wire dataWire
);
	initial begin
		chipEnable = 1'b0;
		serial_clock_in = 1'b0;
		serial_data_in = 1'b0;
	end
	// one clock pulse, data set while low, pin read at the rise
	task automatic pulse(input logic b, output logic r);
		serial_data_in = b;
		#62;
		serial_clock_in = 1'b1;
		r = dataWire;
		#63;
		serial_clock_in = 1'b0;
	endtask
	// address with enable low, data with enable high, word latched at the fall
	task automatic xfer(input logic [7:0] a, input logic [63:0] d, input int n,
		output logic [63:0] got);
		logic r;
		got = '0;
		for (int i = 0; i < 8; i++) pulse(a[i], r);
		#62;
		chipEnable = 1'b1;
		#125;
		for (int i = 0; i < n; i++) begin
			pulse(d[i], r);
			got[i] = r;
		end
		chipEnable = 1'b0;
		serial_data_in = ~serial_data_in;
		#500;
	endtask
endmodule

// *** sccr_regs.vh ***
// constants for the serial configuration, sync protection and group check block
`ifndef SCCR_REGS_VH
`define SCCR_REGS_VH

// address codes, first bit shifted is bit 0
`define SCCR_ADDR_CTRL 8'hfa
`define SCCR_ADDR_READ 8'hfb
`define SCCR_ADDR_CRC 8'hfc

// field widths of the serial words
`define SCCR_ADDR_BITS 8
`define SCCR_WORD_BITS 16
`define SCCR_BYTE_BITS 8

// control word layout
`define SCCR_SEL_LO 8
`define SCCR_SEL_HI 11
`define SCCR_VAL_LO 0
`define SCCR_VAL_HI 7

// register select codes
`define SCCR_SEL_ALLOW 4'h0
`define SCCR_SEL_BLOCK 4'h1
`define SCCR_SEL_FRAME 4'h2
`define SCCR_SEL_MODE 4'h3

// reset values: upper nibble unsynchronized, lower nibble synchronized
`define SCCR_DEF_ALLOW 8'h22
`define SCCR_DEF_PROT 8'h17
`define SCCR_DEF_MODE 8'h00

// nibble positions inside a value
`define SCCR_UNSYNC_LO 4
`define SCCR_UNSYNC_HI 7
`define SCCR_SYNC_LO 0
`define SCCR_SYNC_HI 3

// operating mode bits
`define SCCR_BIT_SYNC_RST 4
`define SCCR_BIT_CRC_RST 7

// group check register
`define SCCR_CRC_INIT 16'h0000
`define SCCR_CRC_POLY 16'h1021

`endif

// *** sccr_sync_prot.v ***
// protection counter that decides sync / no sync from timed match results
`timescale 1ns/1ns
module sccr_sync_prot #(
	parameter CNT_W = 5
) (
	input wire clock,
	input wire reset_n,
	input wire syncReset,
	input wire tick,
	input wire match,
	input wire [3:0] unsyncLimit,
	input wire [3:0] syncLimit,
	output reg inSync_r
);
	reg [CNT_W-1:0] count_r;

	// count stores events so far, so the change happens at event limit+1
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			inSync_r <= 1'b0;
			count_r <= {CNT_W{1'b0}};
		end else if (syncReset) begin
			inSync_r <= 1'b0;
			count_r <= {CNT_W{1'b0}};
		end else if (tick) begin
			if (!inSync_r) begin
				if (!match) begin
					count_r <= {CNT_W{1'b0}};
				end else if (count_r >= {1'b0, unsyncLimit}) begin
					inSync_r <= 1'b1;
					count_r <= {CNT_W{1'b0}};
				end else begin
					count_r <= count_r + 1'b1;
				end
			end else begin
				if (match) begin
					count_r <= {CNT_W{1'b0}};
				end else if (count_r >= {1'b0, syncLimit}) begin
					inSync_r <= 1'b0;
					count_r <= {CNT_W{1'b0}};
				end else begin
					count_r <= count_r + 1'b1;
				end
			end
		end
	end
endmodule

// *** sccr_top.v ***
// serial host control port with sync protection and group check register
//
// Behaviour
// - three address codes decoded, others do nothing
// - control address takes one 16-bit word
// - read address shifts output data per clock
// - check-data address feeds whole bytes to checker
// - bits 11 to 8 select, low byte is value
// - select 0 loads sync word error allowances
// - select 1 loads block protection counts
// - select 2 loads frame protection counts
// - select 3 writes operating mode register
// - sync word accepted within allowed bit errors
// - out of sync, matches count, mismatch clears
// - in sync, mismatches count, match clears
// - stored value is desired count minus one
// - value zero means change on first event
// - block protection defaults eight and two
// - frame protection uses inflection points, same coding
// - reset reloads all configuration defaults
// - result pin high when check register zero
// - mode bit 7 holds check register cleared
// - checker accumulates across separate transfers
// - sync reset bit clears sync state, releases data pin
// - block sync pin high while synchronized
`timescale 1ns/1ns
`include "sccr_regs.vh"
module sccr_top #(
	parameter CNT_W = 5
) (
	input wire clock,
	input wire reset_n,
	input wire chipEnable,
	input wire serial_clock_in,
	input wire serial_data_in,
	output wire dataOutPinOut,
	output wire dataOutPinOe,
	input wire [7:0] readByte,
	output reg readByteTake_r,
	input wire [15:0] block_sync_word,
	input wire [15:0] expectedSyncWord,
	input wire blockTick,
	input wire frameTick,
	input wire frameInflection,
	output wire blockSyncOut,
	output wire frameSyncOut,
	output reg group_check_result_pin_r,
	output reg [7:0] modeCtrl_r
);
	// pin synchronisers: bit 0 enable, bit 1 clock, bit 2 data
	wire [2:0] pinRaw;
	wire [2:0] pinSync;
	reg cePrev_r;
	reg clPrev_r;
	wire ceLevel;
	wire clLevel;
	wire diLevel;
	wire ceRise;
	wire ceFall;
	wire clRise;
	wire clFall;

	// serial shift state
	reg [7:0] addrShift_r;
	reg [7:0] activeAddr_r;
	reg [15:0] dataShift_r;
	reg [4:0] bitCnt_r;
	reg [7:0] readShift_r;
	reg [2:0] readCnt_r;
	reg crcByteValid_r;
	reg [7:0] crcByte_r;

	// configuration registers
	reg [7:0] errAllow_r;
	reg [7:0] blockProt_r;
	reg [7:0] frameProt_r;

	wire isCtrl;
	wire isRead;
	wire isCrc;
	wire [3:0] selCode;
	wire [7:0] selValue;
	wire syncReset;
	wire crcClear;
	wire crcZero;
	wire blockMatch;
	wire [3:0] allowNow;
	wire [4:0] errBits;

	// count of mismatched bits between two sync words
	function [4:0] popCount;
		input [15:0] v;
		integer k;
		begin
			popCount = 5'h00;
			for (k = 0; k < `SCCR_WORD_BITS; k = k + 1) begin
				popCount = popCount + {4'h0, v[k]};
			end
		end
	endfunction

	// raw pins gathered so one loop can synchronise them all
	assign pinRaw = {serial_data_in, serial_clock_in, chipEnable};

	// two flip-flops before any logic reads a pin
	// each pin lives in its own loop body so every flop has one driver
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gSync
			reg meta_r;
			reg stage_r;
			always @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					meta_r <= 1'b0;
					stage_r <= 1'b0;
				end else begin
					meta_r <= pinRaw[g];
					stage_r <= meta_r;
				end
			end
			assign pinSync[g] = stage_r;
		end
	endgenerate

	// only the second stage is ever read
	assign ceLevel = pinSync[0];
	assign clLevel = pinSync[1];
	assign diLevel = pinSync[2];

	// edge history taken from the second stage only
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cePrev_r <= 1'b0;
			clPrev_r <= 1'b0;
		end else begin
			cePrev_r <= ceLevel;
			clPrev_r <= clLevel;
		end
	end

	assign ceRise = ceLevel & ~cePrev_r;
	assign ceFall = ~ceLevel & cePrev_r;
	assign clRise = clLevel & ~clPrev_r;
	assign clFall = ~clLevel & clPrev_r;

	// address decode, any other code leaves every configuration register alone
	assign isCtrl = (activeAddr_r == `SCCR_ADDR_CTRL);
	assign isRead = (activeAddr_r == `SCCR_ADDR_READ);
	assign isCrc = (activeAddr_r == `SCCR_ADDR_CRC);

	// address phase with enable low, data phase with enable high
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			addrShift_r <= 8'h00;
			activeAddr_r <= 8'h00;
			dataShift_r <= 16'h0000;
			bitCnt_r <= 5'h00;
		end else if (ceRise) begin
			activeAddr_r <= addrShift_r;
			bitCnt_r <= 5'h00;
		end else if (ceFall) begin
			activeAddr_r <= 8'h00; // transfer closed
		end else if (clRise && !ceLevel) begin
			addrShift_r <= {diLevel, addrShift_r[7:1]};
		end else if (clRise && ceLevel) begin
			dataShift_r <= {diLevel, dataShift_r[15:1]};
			// past sixteen bits the top bit sticks and the low bits keep
			// counting, so long check streams stay framed in whole bytes
			if (bitCnt_r[4]) begin
				bitCnt_r <= {1'b1, bitCnt_r[3:0] + 4'h1};
			end else begin
				bitCnt_r <= bitCnt_r + 5'h01;
			end
		end
	end

	// a whole byte of check data goes out on its eighth bit
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			crcByteValid_r <= 1'b0;
			crcByte_r <= 8'h00;
		end else begin
			crcByteValid_r <= 1'b0;
			if (clRise && ceLevel && isCrc && (bitCnt_r[2:0] == 3'h7)) begin
				crcByteValid_r <= 1'b1;
				crcByte_r <= {diLevel, dataShift_r[15:9]};
			end
		end
	end

	assign selCode = dataShift_r[`SCCR_SEL_HI:`SCCR_SEL_LO];
	assign selValue = dataShift_r[`SCCR_VAL_HI:`SCCR_VAL_LO];

	// control word applied when enable falls after sixteen bits
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			errAllow_r <= `SCCR_DEF_ALLOW;
			blockProt_r <= `SCCR_DEF_PROT;
			frameProt_r <= `SCCR_DEF_PROT;
			modeCtrl_r <= `SCCR_DEF_MODE;
		end else if (ceFall && isCtrl && (bitCnt_r >= 5'h10)) begin
			case (selCode)
				`SCCR_SEL_ALLOW: begin
					errAllow_r <= selValue;
				end
				`SCCR_SEL_BLOCK: begin
					blockProt_r <= selValue;
				end
				`SCCR_SEL_FRAME: begin
					frameProt_r <= selValue;
				end
				`SCCR_SEL_MODE: begin
					modeCtrl_r <= selValue;
				end
				default: begin
					errAllow_r <= errAllow_r;
				end
			endcase
		end
	end

	// read shifter: first byte on enable rise, next bit per clock fall
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			readShift_r <= 8'hff;
			readCnt_r <= 3'h0;
			readByteTake_r <= 1'b0;
		end else begin
			readByteTake_r <= 1'b0;
			if (ceRise && (addrShift_r == `SCCR_ADDR_READ)) begin
				readShift_r <= readByte;
				readCnt_r <= 3'h0;
				readByteTake_r <= 1'b1;
			end else if (clFall && ceLevel && isRead) begin
				if (readCnt_r == 3'h7) begin
					readShift_r <= readByte;
					readByteTake_r <= 1'b1;
				end else begin
					readShift_r <= {1'b1, readShift_r[7:1]};
				end
				readCnt_r <= readCnt_r + 3'h1;
			end
		end
	end

	// open drain: only ever pulls low, released in sync reset
	assign dataOutPinOut = 1'b0;
	assign dataOutPinOe = isRead & ceLevel & ~readShift_r[0] & ~syncReset;

	assign syncReset = modeCtrl_r[`SCCR_BIT_SYNC_RST];
	assign crcClear = modeCtrl_r[`SCCR_BIT_CRC_RST];

	// sync word recognition with the allowance of the present state
	assign allowNow = blockSyncOut ? errAllow_r[`SCCR_SYNC_HI:`SCCR_SYNC_LO] :
		errAllow_r[`SCCR_UNSYNC_HI:`SCCR_UNSYNC_LO];
	assign errBits = popCount(block_sync_word ^ expectedSyncWord);
	assign blockMatch = (errBits <= {1'b0, allowNow});

	// block sync protection
	sccr_sync_prot #(
		.CNT_W(CNT_W)
	) uBlock (
		.clock(clock),
		.reset_n(reset_n),
		.syncReset(syncReset),
		.tick(blockTick),
		.match(blockMatch),
		.unsyncLimit(blockProt_r[`SCCR_UNSYNC_HI:`SCCR_UNSYNC_LO]),
		.syncLimit(blockProt_r[`SCCR_SYNC_HI:`SCCR_SYNC_LO]),
		.inSync_r(blockSyncOut)
	);

	// frame sync protection on the inflection points
	sccr_sync_prot #(
		.CNT_W(CNT_W)
	) uFrame (
		.clock(clock),
		.reset_n(reset_n),
		.syncReset(syncReset),
		.tick(frameTick),
		.match(frameInflection),
		.unsyncLimit(frameProt_r[`SCCR_UNSYNC_HI:`SCCR_UNSYNC_LO]),
		.syncLimit(frameProt_r[`SCCR_SYNC_HI:`SCCR_SYNC_LO]),
		.inSync_r(frameSyncOut)
	);

	// group check register
	sccr_crc_byte uCrc (
		.clock(clock),
		.reset_n(reset_n),
		.clear(crcClear),
		.byteValid(crcByteValid_r),
		.byteIn(crcByte_r),
		.allZero(crcZero)
	);

	// result pin low in reset, then follows the register
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			group_check_result_pin_r <= 1'b0;
		end else begin
			group_check_result_pin_r <= crcZero;
		end
	end
endmodule

// *** sccr_top_sva.sv ***
// checker on the ports of the serial control block
`timescale 1ns/1ns
module sccr_top_sva #(
	parameter CNT_W = 5
) (
	input wire clock,
	input wire reset_n,
	input wire chipEnable,
	input wire readByteTake_r,
	input wire blockTick,
	input wire frameTick,
	input wire blockSyncOut,
	input wire frameSyncOut,
	input wire group_check_result_pin_r,
	input wire [7:0] modeCtrl_r
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	// outputs tied to the inputs that cause them
	mode_reset_a: assert property ($rose(reset_n) |-> modeCtrl_r == 8'h00)
		else $error("mode not reset");
	mode_latch_a: assert property (!$stable(modeCtrl_r) |-> !chipEnable)
		else $error("mode moved while enabled");
	block_rise_a: assert property ($rose(blockSyncOut) |->
		$past(blockTick) || $past(blockTick, 2)) else $error("block rise");
	block_fall_a: assert property ($fell(blockSyncOut) |->
		$past(blockTick) || $past(blockTick, 2) || modeCtrl_r[4]) else $error("block fall");
	frame_rise_a: assert property ($rose(frameSyncOut) |->
		$past(frameTick) || $past(frameTick, 2)) else $error("frame rise");
	sync_clear_a: assert property (modeCtrl_r[4] [*3] |-> !blockSyncOut && !frameSyncOut)
		else $error("sync kept");
	check_clear_a: assert property (modeCtrl_r[7] [*3] |-> group_check_result_pin_r)
		else $error("check not cleared");
	take_pulse_a: assert property (readByteTake_r |=> !readByteTake_r)
		else $error("take too long");
endmodule

bind sccr_top sccr_top_sva #(.CNT_W(CNT_W)) i_sva (.clock(clock), .reset_n(reset_n),
	.chipEnable(chipEnable), .readByteTake_r(readByteTake_r), .blockTick(blockTick),
	.frameTick(frameTick), .blockSyncOut(blockSyncOut), .frameSyncOut(frameSyncOut),
	.group_check_result_pin_r(group_check_result_pin_r), .modeCtrl_r(modeCtrl_r));

// *** testbench.sv ***
// self-checking bench for the serial control block
`timescale 1ns/1ns
`include "sccr_regs.vh"
module testbench;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] readByte = 8'h00;
	logic [15:0] block_sync_word = 16'h0000;
	logic [15:0] expectedSyncWord = 16'h0000;
	logic blockTick = 1'b0;
	logic frameTick = 1'b0;
	logic frameInflection = 1'b0;
	wire chipEnable, serial_clock_in, serial_data_in, dataOutPinOe, readByteTake_r;
	wire blockSyncOut, frameSyncOut, group_check_result_pin_r;
	wire [7:0] modeCtrl_r;
	wire dataWire = dataOutPinOe ? 1'b0 : 1'b1;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cnt[2];
	logic inSync[2];
	logic [3:0] lu[2];
	logic [3:0] ls[2];
	logic [3:0] allowUnsync, allowSync;
	logic [7:0] mode;
	logic [10:0] q[$];
	logic [63:0] got;
	event look;
	sccr_top i_dut (.clock(clock), .reset_n(reset_n), .chipEnable(chipEnable),
		.serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
		.dataOutPinOut(), .dataOutPinOe(dataOutPinOe), .readByte(readByte),
		.readByteTake_r(readByteTake_r), .block_sync_word(block_sync_word),
		.expectedSyncWord(expectedSyncWord), .blockTick(blockTick), .frameTick(frameTick),
		.frameInflection(frameInflection), .blockSyncOut(blockSyncOut),
		.frameSyncOut(frameSyncOut), .group_check_result_pin_r(group_check_result_pin_r),
		.modeCtrl_r(modeCtrl_r));
	sccr_host_model i_host (.chipEnable(chipEnable), .serial_clock_in(serial_clock_in),
		.serial_data_in(serial_data_in), .dataWire(dataWire));
	initial begin
		forever #5 clock = ~clock;
	end
	// cycle ceiling cuts a hang short
	initial begin
		repeat (40000) @(posedge clock);
		n_mismatch++;
		complete_run;
	end
	// watcher compares each result with the oldest note
	always @(look) begin
		logic [10:0] e;
		logic [7:0] o;
		e = q.pop_front();
		case (e[10:8])
			0: o = modeCtrl_r;
			1: o = {7'h0, blockSyncOut};
			2: o = {7'h0, frameSyncOut};
			3: o = {7'h0, group_check_result_pin_r};
			default: o = got[7:0];
		endcase
		samples_checked++;
		if (o !== e[7:0]) begin
			n_mismatch++;
			$display("CHECK FAILED %0t kind %0d got %h exp %h", $time, e[10:8], o, e[7:0]);
		end
	end
	task automatic chk(input logic [2:0] c, input logic [7:0] e);
		q.push_back({c, e});
		->look;
		#1;
	endtask
	task automatic dflt;
		{allowUnsync, allowSync} = 8'h22;
		lu = '{4'h1, 4'h1};
		ls = '{4'h7, 4'h7};
		mode = 8'h00;
		inSync = '{1'b0, 1'b0};
		cnt = '{0, 0};
	endtask
	// control word write, mirrored into the reference copy
	task automatic ctrl(input logic [7:0] s, input logic [7:0] v);
		i_host.xfer(`SCCR_ADDR_CTRL, {48'h0, s, v}, 16, got);
		case (s[3:0])
			0: {allowUnsync, allowSync} = v;
			1: {lu[0], ls[0]} = v;
			2: {lu[1], ls[1]} = v;
			3: mode = v;
			default: ;
		endcase
		if (mode[4]) dflt_sync();
		chk(0, mode);
	endtask
	task automatic dflt_sync;
		inSync = '{1'b0, 1'b0};
		cnt = '{0, 0};
	endtask
	// one block (d 0) or frame (d 1) tick and the reference step
	task automatic tick(input int d, input logic m);
		logic [3:0] al;
		al = inSync[0] ? allowSync : allowUnsync;
		@(negedge clock);
		expectedSyncWord = 16'($urandom);
		block_sync_word = expectedSyncWord ^ ((16'h1 << (m ? al : al + 1)) - 16'h1);
		frameInflection = m;
		blockTick = (d == 0);
		frameTick = (d == 1);
		@(negedge clock);
		blockTick = 1'b0;
		frameTick = 1'b0;
		if (!inSync[d]) cnt[d] = m ? cnt[d] + 1 : 0;
		else cnt[d] = m ? 0 : cnt[d] + 1;
		if (cnt[d] > (inSync[d] ? ls[d] : lu[d])) begin
			inSync[d] = !inSync[d];
			cnt[d] = 0;
		end
		@(negedge clock);
		chk(3'(d + 1), {7'h0, inSync[d]});
	endtask
	task automatic run(input int n);
		int d;
		logic m;
		repeat (n) begin
			d = $urandom % 2;
			m = 1'($urandom);
			repeat (1 + $urandom % 10) tick(d, m);
		end
	endtask
	function automatic logic [15:0] cstep(input logic [15:0] c, input logic b);
		return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `SCCR_CRC_POLY : 16'h0000);
	endfunction
	task automatic complete_run;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		logic [63:0] d;
		logic [15:0] crc;
		void'($urandom(32));
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		dflt();
		@(negedge clock);
		chk(3, 1);
		ctrl(8'h03, 8'($urandom) & 8'h6f);
		ctrl(8'hf3, 8'($urandom) & 8'h6f);
		ctrl(8'ha1, 8'h17);
		i_host.xfer(8'hfd, 64'h03ff, 16, got);
		i_host.xfer(`SCCR_ADDR_CTRL, 64'h03ff, 15, got);
		chk(0, mode);
		ctrl(8'h00, 8'h10);
		ctrl(8'h01, 8'h22);
		ctrl(8'h02, 8'h00);
		run(16);
		ctrl(8'h03, 8'h10);
		chk(1, 0);
		chk(2, 0);
		ctrl(8'h03, 8'h00);
		run(16);
		@(negedge clock);
		reset_n = 1'b0;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		dflt();
		@(negedge clock);
		chk(0, 0);
		run(16);
		ctrl(8'h03, 8'h80);
		chk(3, 1);
		ctrl(8'h03, 8'h00);
		crc = 16'h0000;
		d = {$urandom, $urandom};
		for (int i = 0; i < 48; i++) crc = cstep(crc, d[i]);
		i_host.xfer(`SCCR_ADDR_CRC, d, 48, got);
		chk(3, {7'h0, crc == 16'h0000});
		for (int i = 0; i < 16; i++) d[i] = crc[15 - i];
		i_host.xfer(`SCCR_ADDR_CRC, d, 19, got);
		chk(3, 1);
		i_host.xfer(`SCCR_ADDR_CRC, 64'h1, 8, got);
		chk(3, 0);
		repeat (3) begin
			@(negedge clock);
			readByte = 8'($urandom);
			i_host.xfer(`SCCR_ADDR_READ, 64'h0, 8, got);
			chk(4, readByte);
		end
		complete_run;
	end
endmodule
